//--- design/tomc_regs.vh
// Register offsets, field positions, reset values and mode codes for the output-mode block
`ifndef TOMC_REGS_VH
`define TOMC_REGS_VH
`define TOMC_OFF_MODE_CTRL 12'h024
`define TOMC_OFF_MODE_EXT 12'h028
`define TOMC_OFF_CMP_A 12'h02C
`define TOMC_OFF_CMP_B 12'h030
`define TOMC_OFF_STATUS 12'h034
`define TOMC_OFF_PRESCALE 12'h038
`define TOMC_MODE_CTRL_RST 8'h00
`define TOMC_MODE_CTRL_MASK 8'hF3
`define TOMC_CHA_HI 7
`define TOMC_CHA_LO 6
`define TOMC_CHB_HI 5
`define TOMC_CHB_LO 4
`define TOMC_WGM_HI 1
`define TOMC_WGM_LO 0
`define TOMC_WGM_NORMAL 3'h0
`define TOMC_WGM_PC_MAX 3'h1
`define TOMC_WGM_CTC 3'h2
`define TOMC_WGM_FAST_MAX 3'h3
`define TOMC_WGM_PC_OCA 3'h5
`define TOMC_WGM_FAST_OCA 3'h7
`define TOMC_CNT_MAX 8'hFF
`define TOMC_CNT_BOTTOM 8'h00
`define TOMC_PRESCALE_RST 16'h0000
`endif

//--- design/tomc_chan.v
// One compare-output waveform channel
`timescale 1ns/1ps
`default_nettype none
module tomc_chan #(
  parameter CAN_TOGGLE_PWM = 1
) (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire [1:0] out_mode,
  input wire [2:0] wgm,
  input wire is_fast,
  input wire is_pc,
  input wire match,
  input wire cmp_is_top,
  input wire at_bottom,
  input wire at_top,
  input wire counting_up,
  input wire force_match,
  output reg wave_q
);
  reg wave_d;
  always @*
  begin
    wave_d = wave_q;
    if (!is_fast && !is_pc)
    begin
      if ((match && tick) || force_match)
      begin
        case (out_mode)
          2'h1: wave_d = ~wave_q;
          2'h2: wave_d = 1'b0;
          2'h3: wave_d = 1'b1;
          default: wave_d = wave_q;
        endcase
      end
    end
    else if (tick)
    begin
      if (out_mode == 2'h1)
      begin
        // Toggle only with top-from-compare modes; other channel has it reserved
        if (CAN_TOGGLE_PWM != 0 && wgm[2] && match)
          wave_d = ~wave_q;
      end
      else if (out_mode[1] && is_fast)
      begin
        // Compare equal to top: match ignored, level set at bottom only
        if (at_bottom)
          wave_d = ~out_mode[0];
        else if (match && !cmp_is_top)
          wave_d = out_mode[0];
      end
      else if (out_mode[1] && is_pc)
      begin
        // Level at top equals the down-count action, keeping symmetry round bottom
        if (cmp_is_top && at_top)
          wave_d = ~out_mode[0];
        else if (match && !cmp_is_top)
          wave_d = counting_up ? out_mode[0] : ~out_mode[0];
      end
    end
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wave_q <= 1'b0;
    else
      wave_q <= wave_d;
  end
endmodule // tomc_chan
`default_nettype wire

//--- design/tomc_top.v
// Output-mode control of an 8-bit timer with APB registers and two waveform pins
// Function
// - Nonzero mode field hands pin to waveform
// - Mode field meaning depends on waveform mode
// - Channel A non-PWM: off, toggle, clear, set
// - Channel B non-PWM: off, toggle, clear, set
// - Channel A fast PWM inverting or non-inverting
// - Channel A PWM 01 toggles only with top bit
// - Fast PWM compare at top: bottom action only
// - Channel A phase-correct up/down match actions
// - Phase-correct compare at top: act at top
// - Channel B fast PWM; 01 reserved
// - Channel B phase-correct; 01 reserved
// - Channel B compare at top: equal to current top value
// - Low two bits plus top bit select mode
// - Decode modes 0,1,2,3,5,7; 4,6 reserved
// - Bits 3 and 2 read zero
`timescale 1ns/1ps
`default_nettype none
`include "tomc_regs.vh"
module tomc_top #(
  parameter ADDR_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg chan_a_waveform_out,
  output reg chan_a_pin_owned,
  output reg chan_b_waveform_out,
  output reg chan_b_pin_owned
);
  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] mode_ctrl_q;
  reg waveform_mode_top_bit_q;
  reg [7:0] chan_a_compare_value_q;
  reg [7:0] chan_b_compare_value_q;
  reg [15:0] prescale_q;
  reg [15:0] div_cnt_q;
  reg [7:0] count_q;
  reg up_q;
  reg [7:0] ocra_act_q;
  reg [7:0] ocrb_act_q;
  reg force_a_q;
  reg force_b_q;
  wire wave_a;
  wire wave_b;
  wire [1:0] chan_a_output_mode = mode_ctrl_q[`TOMC_CHA_HI:`TOMC_CHA_LO];
  wire [1:0] chan_b_output_mode = mode_ctrl_q[`TOMC_CHB_HI:`TOMC_CHB_LO];
  wire [1:0] waveform_mode_low_bits = mode_ctrl_q[`TOMC_WGM_HI:`TOMC_WGM_LO];
  wire [2:0] waveform_mode_select = {waveform_mode_top_bit_q, waveform_mode_low_bits};
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  // ****************************************
  // Mode decode
  // ****************************************
  reg is_fast;
  reg is_pc;
  reg top_from_a;
  always @*
  begin
    is_fast = 1'b0;
    is_pc = 1'b0;
    top_from_a = 1'b0;
    case (waveform_mode_select)
      `TOMC_WGM_NORMAL: top_from_a = 1'b0;
      `TOMC_WGM_PC_MAX: is_pc = 1'b1;
      `TOMC_WGM_CTC: top_from_a = 1'b1;
      `TOMC_WGM_FAST_MAX: is_fast = 1'b1;
      `TOMC_WGM_PC_OCA:
      begin
        is_pc = 1'b1;
        top_from_a = 1'b1;
      end
      `TOMC_WGM_FAST_OCA:
      begin
        is_fast = 1'b1;
        top_from_a = 1'b1;
      end
      // Reserved codes behave as a stopped normal counter
      default: top_from_a = 1'b0;
    endcase
  end
  wire reserved_mode = (waveform_mode_select == 3'h4) || (waveform_mode_select == 3'h6);
  // ****************************************
  // Counter and tick divider
  // ****************************************
  // Compare by range so lowering the prescale never waits for a 16-bit wrap
  wire tick = (div_cnt_q >= prescale_q) && !reserved_mode;
  wire [7:0] top_val = top_from_a ? ocra_act_q : `TOMC_CNT_MAX;
  wire at_top = (count_q == top_val);
  wire at_bottom = (count_q == `TOMC_CNT_BOTTOM);
  wire match_a = (count_q == ocra_act_q);
  wire match_b = (count_q == ocrb_act_q);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt_q <= 16'h0000;
      count_q <= 8'h00;
      up_q <= 1'b1;
      ocra_act_q <= 8'h00;
      ocrb_act_q <= 8'h00;
    end
    else
    begin
      div_cnt_q <= tick ? 16'h0000 : div_cnt_q + 16'h0001;
      // Double buffering keeps PWM glitch free; immediate load otherwise
      if (!is_fast && !is_pc)
      begin
        ocra_act_q <= chan_a_compare_value_q;
        ocrb_act_q <= chan_b_compare_value_q;
      end
      else if (tick && ((is_fast && at_top) || (is_pc && at_top)))
      begin
        ocra_act_q <= chan_a_compare_value_q;
        ocrb_act_q <= chan_b_compare_value_q;
      end
      if (tick)
      begin
        if (is_pc)
        begin
          if (at_top)
          begin
            up_q <= 1'b0;
            count_q <= count_q - 8'h01;
          end
          else if (at_bottom && !up_q)
          begin
            up_q <= 1'b1;
            count_q <= count_q + 8'h01;
          end
          else
            count_q <= up_q ? count_q + 8'h01 : count_q - 8'h01;
        end
        else
        begin
          up_q <= 1'b1;
          count_q <= at_top ? `TOMC_CNT_BOTTOM : count_q + 8'h01;
        end
      end
    end
  end
  // ****************************************
  // Register writes
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ctrl_q <= `TOMC_MODE_CTRL_RST;
      waveform_mode_top_bit_q <= 1'b0;
      chan_a_compare_value_q <= 8'h00;
      chan_b_compare_value_q <= 8'h00;
      prescale_q <= `TOMC_PRESCALE_RST;
      force_a_q <= 1'b0;
      force_b_q <= 1'b0;
    end
    else
    begin
      force_a_q <= 1'b0;
      force_b_q <= 1'b0;
      if (wr && !pready)
      begin
        case (paddr)
          `TOMC_OFF_MODE_CTRL: mode_ctrl_q <= pwdata[7:0] & `TOMC_MODE_CTRL_MASK;
          `TOMC_OFF_MODE_EXT:
          begin
            waveform_mode_top_bit_q <= pwdata[0];
            // Force strobes act only outside PWM modes
            force_a_q <= pwdata[1] && !is_fast && !is_pc;
            force_b_q <= pwdata[2] && !is_fast && !is_pc;
          end
          `TOMC_OFF_CMP_A: chan_a_compare_value_q <= pwdata[7:0];
          `TOMC_OFF_CMP_B: chan_b_compare_value_q <= pwdata[7:0];
          `TOMC_OFF_PRESCALE: prescale_q <= pwdata[15:0];
          default: force_a_q <= 1'b0;
        endcase
      end
    end
  end
  // ****************************************
  // APB answer
  // ****************************************
  reg [31:0] rd_d;
  reg hit;
  always @*
  begin
    rd_d = 32'h00000000;
    hit = 1'b1;
    case (paddr)
      `TOMC_OFF_MODE_CTRL: rd_d = {24'h000000, mode_ctrl_q & `TOMC_MODE_CTRL_MASK};
      `TOMC_OFF_MODE_EXT: rd_d = {31'h00000000, waveform_mode_top_bit_q};
      `TOMC_OFF_CMP_A: rd_d = {24'h000000, chan_a_compare_value_q};
      `TOMC_OFF_CMP_B: rd_d = {24'h000000, chan_b_compare_value_q};
      `TOMC_OFF_STATUS: rd_d = {21'h000000, up_q, chan_b_waveform_out, chan_a_waveform_out, count_q};
      `TOMC_OFF_PRESCALE: rd_d = {16'h0000, prescale_q};
      default: hit = 1'b0;
    endcase
  end
  // One wait state: answer on the second access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !hit;
      prdata <= (acc && !pready && !pwrite) ? rd_d : 32'h00000000;
    end
  end
  // ****************************************
  // Channels and pin ownership
  // ****************************************
  tomc_chan #(.CAN_TOGGLE_PWM(1)) u_chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .out_mode(chan_a_output_mode),
    .wgm(waveform_mode_select),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .match(match_a),
    .cmp_is_top(top_from_a || ocra_act_q == `TOMC_CNT_MAX),
    .at_bottom(at_bottom),
    .at_top(at_top),
    .counting_up(up_q),
    .force_match(force_a_q),
    .wave_q(wave_a)
  );
  tomc_chan #(.CAN_TOGGLE_PWM(0)) u_chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .out_mode(chan_b_output_mode),
    .wgm(waveform_mode_select),
    .is_fast(is_fast),
    .is_pc(is_pc),
    .match(match_b),
    .cmp_is_top(ocrb_act_q == top_val),
    .at_bottom(at_bottom),
    .at_top(at_top),
    .counting_up(up_q),
    .force_match(force_b_q),
    .wave_q(wave_b)
  );
  // Pin driver still needs the port direction bit outside this block
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_a_waveform_out <= 1'b0;
      chan_b_waveform_out <= 1'b0;
      chan_a_pin_owned <= 1'b0;
      chan_b_pin_owned <= 1'b0;
    end
    else
    begin
      chan_a_waveform_out <= wave_a;
      chan_b_waveform_out <= wave_b;
      chan_a_pin_owned <= |chan_a_output_mode;
      chan_b_pin_owned <= |chan_b_output_mode;
    end
  end
endmodule // tomc_top
`default_nettype wire

//--- tb/tomc_load.sv
// Pin load model for the two waveform pins
`timescale 1ns/1ps
`default_nettype none
module tomc_load (
  input wire logic wave_a,
  input wire logic own_a,
  input wire logic wave_b,
  input wire logic own_b,
  output logic pad_a,
  output logic pad_b
);
  // Direction set to output; a released pin shows its pull-up
  assign pad_a = own_a ? wave_a : 1'b1;
  assign pad_b = own_b ? wave_b : 1'b1;
endmodule // tomc_load
`default_nettype wire

//--- tb/tomc_checker.sv
// Port assertions for the output-mode block
`timescale 1ns/1ps
`default_nettype none
module tomc_checker #(
  parameter ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chan_a_waveform_out,
  input wire logic chan_a_pin_owned,
  input wire logic chan_b_waveform_out,
  input wire logic chan_b_pin_owned
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_ctl_wr;
    pready && pwrite && paddr == 12'h024;
  endsequence
  property p_rdy; s_acc |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside answer");
  property p_resv; pready && !pwrite && paddr == 12'h024 |-> prdata[3:2] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_own_a; s_ctl_wr ##0 pwdata[7:6] != 2'h0 |-> ##[1:3] chan_a_pin_owned; endproperty
  a_own_a: assert property (p_own_a) else $error("pin A not taken");
  property p_rel_b; s_ctl_wr ##0 pwdata[5:4] == 2'h0 |-> ##[1:3] !chan_b_pin_owned; endproperty
  a_rel_b: assert property (p_rel_b) else $error("pin B not released");
  property p_rst; $rose(presetn) |-> !chan_a_pin_owned && !chan_b_pin_owned; endproperty
  a_rst: assert property (p_rst) else $error("pin owned after reset");
endmodule // tomc_checker
`default_nettype wire
bind tomc_top tomc_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chan_a_waveform_out(chan_a_waveform_out), .chan_a_pin_owned(chan_a_pin_owned),
  .chan_b_waveform_out(chan_b_waveform_out), .chan_b_pin_owned(chan_b_pin_owned));

//--- tb/tomc_bench.sv
// Register and waveform bench for the output-mode block
`timescale 1ns/1ps
`default_nettype none
module tomc_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, erv, wa, oa, wb, ob, pad_a, pad_b;
  logic [1:0] fm [6] = '{2'h2, 2'h1, 2'h1, 2'h3, 2'h2, 2'h3};
  logic fe [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int err_count = 0, n_checks = 0;
  always #2 pclk = ~pclk;
  tomc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a_waveform_out(wa), .chan_a_pin_owned(oa),
    .chan_b_waveform_out(wb), .chan_b_pin_owned(ob));
  tomc_load u_load (.wave_a(wa), .own_a(oa), .wave_b(wb), .own_b(ob), .pad_a(pad_a),
    .pad_b(pad_b));
  task results;
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    n_checks++;
    if (tol == 0 ? got !== exp : (got > exp + tol || got + tol < exp))
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Edge first, so a release never meets the next setup
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      err_count++;
      results;
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e, 0);
  endtask
  task pwm(input logic [7:0] c, input logic [7:0] x, input logic [7:0] ca, input logic [7:0] cb);
    wr(12'h02C, {24'h0, ca});
    wr(12'h030, {24'h0, cb});
    wr(12'h028, {24'h0, x});
    wr(12'h024, {24'h0, c});
    // Compare values load at TOP; one full slope pair settles them
    repeat (600) @(posedge pclk);
  endtask
  task meas(input int n, input int ea, input int eb, input int tol);
    int ha, hb;
    ha = 0;
    hb = 0;
    repeat (n)
    begin
      @(posedge pclk);
      ha += (pad_a === 1'b1);
      hb += (pad_b === 1'b1);
    end
    chk(ha, ea, tol);
    chk(hb, eb, tol);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h024, 32'h0);
    wr(12'h024, 32'hFF);
    rdc(12'h024, 32'hF3);
    wr(12'h024, 32'h40);
    apb(1'b0, 12'h040, 32'h0);
    chk(erv, 32'h1, 0);
    wr(12'h02C, 32'h80);
    wr(12'h030, 32'h80);
    // Slow tick keeps real matches out of the forced ones
    wr(12'h038, 32'hFFFF);
    foreach (fm[k])
    begin
      wr(12'h024, {24'h0, fm[k], fm[k], 4'h0});
      wr(12'h028, 32'h6);
      repeat (6) @(posedge pclk);
      chk({pad_a, pad_b}, {30'h0, fe[k], fe[k]}, 0);
    end
    wr(12'h038, 32'h0);
    pwm(8'hB3, 8'h0, 8'h40, 8'h40);
    meas(512, 128, 384, 4);
    pwm(8'hB1, 8'h0, 8'h40, 8'h40);
    meas(1020, 256, 764, 6);
    pwm(8'hB3, 8'h0, 8'hFF, 8'hFF);
    meas(512, 512, 0, 2);
    pwm(8'hA1, 8'h0, 8'hFF, 8'hFF);
    meas(1020, 1020, 1020, 2);
    pwm(8'h43, 8'h1, 8'h40, 8'h40);
    meas(1020, 510, 1020, 70);
    results;
  end
endmodule // tomc_bench
`default_nettype wire
